// ### sltp_lane_fmt.sv
// Lane formatter, test-pattern generator and power-down control for two eight-lane links
//
// Added by the designer: the APB register port and the placing of the registers.
`timescale 1ns/1ps
// Operation
// - Format 6 puts A0,A1 on link A lanes 0,1 and B0,B1 on link B.
// - Format 7 puts A0-A3 on link A lanes 0-3, B0-B3 on link B.
// - Format 17 sends even samples on link A, odd samples on link B.
// - Format 18 puts A0-A7 on link A and B0-B7 on link B.
// - Power-down pin or config bit disables every lane driver.
// - Test select picks the mode; lane power always follows link format.
// - PRBS bypasses the encoder; each lane starts at a distinct phase.
// - PRBS taps 6/7, 14/15, 18/23 with lengths 127, 32767, 8388607.
// - Ramp sends identical octets 0x00..0xFF on all active lanes after alignment.
// - Only the short transport pattern exists; no long pattern.
// - Short transport: lane k sends k, then its complement, repeating.
// - D21.5 mode sends a continuous D21.5 stream on active lanes.
// - K28.5 mode sends a continuous K28.5 stream on active lanes.
// - Repeated alignment mode resends the alignment sequence, never data.
// - A sync request in that mode forces code group sync, then alignment.
// - RPAT mode feeds the encoder a fixed repeating twelve-octet sequence.
// - Octets go MSB first; unused tail bits are zero.
// - Lowest lanes of each link used; higher lanes powered down.
module sltp_lane_fmt #(
  parameter int ILAS_MF = sltp_pkg::ILAS_MF_COUNT,
  parameter int MF_LEN  = sltp_pkg::MF_OCTETS
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic [11:0]  paddr,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [31:0]  pwdata,
  output logic      [31:0]  prdata,
  output logic              pready,
  output logic              pslverr,
  input  wire logic         powerdown_pin,
  input  wire logic         sync_req_n,
  input  wire logic [127:0] samples,
  output logic      [63:0]  link_a_lanes,
  output logic      [63:0]  link_b_lanes,
  output logic      [15:0]  lane_k,
  output logic      [15:0]  lane_raw,
  output logic      [15:0]  lane_drive_en
);
  localparam int ILAS_LEN = ILAS_MF * MF_LEN;

  logic [1:0]  ctrl, next_ctrl;
  logic [4:0]  fmt, next_fmt;
  logic [3:0]  test_sel, next_test_sel;
  logic [3:0]  test_act, next_test_act;
  logic [31:0] next_prdata;
  logic        next_pready, next_pslverr;
  sltp_pkg::sltp_link_e link, next_link;
  logic [15:0] ilas_cnt, next_ilas_cnt;
  logic [7:0]  ramp, next_ramp;
  logic        stp, next_stp;
  logic [3:0]  rpat_idx, next_rpat_idx;
  logic [22:0] lfsr [16];
  logic [22:0] next_lfsr [16];
  logic [127:0] next_lanes;
  logic [15:0] next_k, next_raw, next_en;
  logic        pd, run, is_prbs;
  logic [7:0]  mask;

  // Power-down from pin or config bit, lane mask from format
  always_comb begin
    pd = powerdown_pin | ctrl[sltp_pkg::CTRL_PWRDN_BIT];
    case (fmt)
      sltp_pkg::FMT_DUAL4:    mask = 8'h03;
      sltp_pkg::FMT_DUAL8:    mask = 8'h0F;
      sltp_pkg::FMT_SINGLE16: mask = 8'hFF;
      sltp_pkg::FMT_DUAL16:   mask = 8'hFF;
      default:                mask = 8'h00;
    endcase
    run = ctrl[sltp_pkg::CTRL_LINK_EN_BIT] & ~pd & (mask != 8'h00);
    is_prbs = (test_act == sltp_pkg::T_PRBS7) | (test_act == sltp_pkg::T_PRBS15) |
              (test_act == sltp_pkg::T_PRBS23);
  end

  // APB slave, one wait state
  always_comb begin
    next_ctrl     = ctrl;
    next_fmt      = fmt;
    next_test_sel = test_sel;
    next_test_act = test_act;
    next_prdata   = prdata;
    next_pslverr  = pslverr;
    next_pready   = psel & penable & ~pready;
    if (psel & ~penable) begin
      next_pslverr = 1'b0;
      case (paddr)
        sltp_pkg::ADDR_CTRL: next_prdata = {30'h0, ctrl};
        sltp_pkg::ADDR_FMT:  next_prdata = {27'h0, fmt};
        sltp_pkg::ADDR_TEST: next_prdata = {28'h0, test_sel};
        sltp_pkg::ADDR_STAT: begin
          next_prdata = 32'h0;
          next_prdata[sltp_pkg::STAT_LINK_LSB +: 4]  = link;
          next_prdata[sltp_pkg::STAT_PD_BIT]         = pd;
          next_prdata[sltp_pkg::STAT_LANE_LSB +: 16] = lane_drive_en;
          next_prdata[sltp_pkg::STAT_TEST_LSB +: 4]  = test_act;
        end
        default: begin
          next_prdata  = 32'h0;
          next_pslverr = 1'b1;
        end
      endcase
    end
    if (psel & penable & pready & pwrite) begin
      case (paddr)
        sltp_pkg::ADDR_CTRL: next_ctrl     = pwdata[1:0];
        sltp_pkg::ADDR_FMT:  next_fmt      = pwdata[4:0];
        sltp_pkg::ADDR_TEST: next_test_sel = pwdata[3:0];
        default: ;
      endcase
    end
    if (!ctrl[sltp_pkg::CTRL_LINK_EN_BIT]) next_test_act = test_sel;
  end

  // Link layer sequencing
  always_comb begin
    next_link     = link;
    next_ilas_cnt = ilas_cnt;
    next_ramp     = ramp;
    next_stp      = stp;
    next_rpat_idx = rpat_idx;
    case (link)
      sltp_pkg::LS_OFF: begin
        if (run) next_link = sltp_pkg::LS_CGS;
      end
      sltp_pkg::LS_CGS: begin
        if (!run) begin
          next_link = sltp_pkg::LS_OFF;
        end else if (sync_req_n) begin
          next_link     = sltp_pkg::LS_ILAS;
          next_ilas_cnt = 16'h0000;
        end
      end
      sltp_pkg::LS_ILAS: begin
        if (!run) begin
          next_link = sltp_pkg::LS_OFF;
        end else if (!sync_req_n) begin
          next_link = sltp_pkg::LS_CGS;
        end else if (ilas_cnt == 16'(ILAS_LEN - 1)) begin
          next_ilas_cnt = 16'h0000;
          if (test_act != sltp_pkg::T_REPILA) begin
            next_link     = sltp_pkg::LS_DATA;
            next_ramp     = 8'h00;
            next_stp      = 1'b0;
            next_rpat_idx = 4'h0;
          end
        end else begin
          next_ilas_cnt = ilas_cnt + 16'h0001;
        end
      end
      sltp_pkg::LS_DATA: begin
        if (!run) begin
          next_link = sltp_pkg::LS_OFF;
        end else if (!sync_req_n) begin
          next_link = sltp_pkg::LS_CGS;
        end else begin
          next_ramp     = ramp + 8'h01;
          next_stp      = ~stp;
          next_rpat_idx = (rpat_idx == sltp_pkg::RPAT_LAST) ? 4'h0 : rpat_idx + 4'h1;
        end
      end
      default: next_link = sltp_pkg::LS_OFF;
    endcase
  end

  // Per-lane octet selection and PRBS stepping
  always_comb begin
    logic [22:0] s;
    logic        b;
    logic [7:0]  oct, prbs_oct;
    logic [2:0]  idx;
    logic        on;
    s = 23'h0;
    b = 1'b0;
    oct = 8'h00;
    prbs_oct = 8'h00;
    idx = 3'h0;
    on = 1'b0;
    next_lanes = 128'h0;
    next_k = 16'h0000;
    next_raw = 16'h0000;
    next_en = 16'h0000;
    for (int l = 0; l < 16; l++) begin
      idx = 3'(l % 8);
      on = mask[idx] & ~pd;
      next_en[l] = on;
      // eight PRBS steps per octet, MSB first
      s = lfsr[l];
      for (int j = 0; j < 8; j++) begin
        case (test_act)
          sltp_pkg::T_PRBS7:  b = (s[6:0] == 7'h00) | (s[5] ^ s[6]);
          sltp_pkg::T_PRBS15: b = (s[14:0] == 15'h0000) | (s[13] ^ s[14]);
          default:            b = (s == 23'h0) | (s[17] ^ s[22]);
        endcase
        prbs_oct[7 - j] = b;
        s = {s[21:0], b};
      end
      next_lfsr[l] = (is_prbs && on) ? s : lfsr[l];
      oct = 8'h00;
      if (on && is_prbs) begin
        oct = prbs_oct;
        next_raw[l] = 1'b1;
      end else if (on && test_act == sltp_pkg::T_D21_5) begin
        oct = sltp_pkg::CH_D21_5;
      end else if (on && test_act == sltp_pkg::T_K28_5) begin
        oct = sltp_pkg::CH_K28_5;
        next_k[l] = 1'b1;
      end else if (on) begin
        case (link)
          sltp_pkg::LS_CGS: begin
            oct = sltp_pkg::CH_K28_5;
            next_k[l] = 1'b1;
          end
          sltp_pkg::LS_ILAS: begin
            if (ilas_cnt % 16'(MF_LEN) == 16'h0000) begin
              oct = sltp_pkg::CH_K28_0;
              next_k[l] = 1'b1;
            end else if (ilas_cnt % 16'(MF_LEN) == 16'(MF_LEN - 1)) begin
              oct = sltp_pkg::CH_K28_3;
              next_k[l] = 1'b1;
            end else begin
              oct = ilas_cnt[7:0];
            end
          end
          sltp_pkg::LS_DATA: begin
            case (test_act)
              sltp_pkg::T_RAMP: oct = ramp;
              sltp_pkg::T_STP:  oct = stp ? ~{5'h00, idx} : {5'h00, idx};
              sltp_pkg::T_RPAT: oct = sltp_pkg::sltp_rpat(rpat_idx);
              default: begin
                // format 17: even samples on A, odd on B; other formats: samples 0-7 on A, 8-15 on B
                if (fmt == sltp_pkg::FMT_SINGLE16) oct = samples[(2 * idx + l / 8) * 8 +: 8];
                else oct = samples[(idx + 8 * (l / 8)) * 8 +: 8];
              end
            endcase
          end
          default: oct = 8'h00;
        endcase
      end
      // octet MSB first, idle lanes zero
      next_lanes[l * 8 +: 8] = oct;
    end
  end

  // Registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl          <= sltp_pkg::CTRL_RST;
      fmt           <= sltp_pkg::FMT_RST;
      test_sel      <= sltp_pkg::TEST_RST;
      test_act      <= sltp_pkg::TEST_RST;
      prdata        <= 32'h0;
      pready        <= 1'b0;
      pslverr       <= 1'b0;
      link          <= sltp_pkg::LS_OFF;
      ilas_cnt      <= 16'h0000;
      ramp          <= 8'h00;
      stp           <= 1'b0;
      rpat_idx      <= 4'h0;
      link_a_lanes  <= 64'h0;
      link_b_lanes  <= 64'h0;
      lane_k        <= 16'h0000;
      lane_raw      <= 16'h0000;
      lane_drive_en <= 16'h0000;
      for (int i = 0; i < 16; i++) lfsr[i] <= sltp_pkg::PRBS_SEED ^ 23'(i * 37 + 1);
    end else begin
      ctrl          <= next_ctrl;
      fmt           <= next_fmt;
      test_sel      <= next_test_sel;
      test_act      <= next_test_act;
      prdata        <= next_prdata;
      pready        <= next_pready;
      pslverr       <= next_pslverr;
      link          <= next_link;
      ilas_cnt      <= next_ilas_cnt;
      ramp          <= next_ramp;
      stp           <= next_stp;
      rpat_idx      <= next_rpat_idx;
      link_a_lanes  <= next_lanes[63:0];
      link_b_lanes  <= next_lanes[127:64];
      lane_k        <= next_k;
      lane_raw      <= next_raw;
      lane_drive_en <= next_en;
      for (int i = 0; i < 16; i++) lfsr[i] <= next_lfsr[i];
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_pd_off;
    pd |=> lane_drive_en == 16'h0000;
  endproperty
  a_pd_off: assert property (p_pd_off) else $error("lanes driven in power-down");
  property p_lane_mask;
    (!pd && fmt == sltp_pkg::FMT_DUAL4) |=> lane_drive_en == 16'h0303;
  endproperty
  a_lane_mask: assert property (p_lane_mask) else $error("wrong lane set for four lanes");
  property p_test_power;
    (!pd && fmt == sltp_pkg::FMT_DUAL8 && test_act == sltp_pkg::T_K28_5) |=> lane_drive_en == 16'h0F0F;
  endproperty
  a_test_power: assert property (p_test_power) else $error("test mode changed lane power");
  property p_hold_test;
    ctrl[sltp_pkg::CTRL_LINK_EN_BIT] |=> $stable(test_act);
  endproperty
  a_hold_test: assert property (p_hold_test) else $error("pattern changed while linked");
  property p_k28;
    (!pd && fmt == sltp_pkg::FMT_DUAL8 && test_act == sltp_pkg::T_K28_5)
      |=> lane_k == 16'h0F0F && link_b_lanes[31:24] == sltp_pkg::CH_K28_5;
  endproperty
  a_k28: assert property (p_k28) else $error("K28.5 stream broken");
  property p_d21;
    (!pd && mask[0] && test_act == sltp_pkg::T_D21_5) |=> link_a_lanes[7:0] == 8'hB5 && !lane_k[0];
  endproperty
  a_d21: assert property (p_d21) else $error("D21.5 stream broken");
  property p_map4;
    (!pd && link == sltp_pkg::LS_DATA && test_act == sltp_pkg::T_NORMAL && fmt == sltp_pkg::FMT_DUAL4)
      |=> link_a_lanes[15:8] == $past(samples[15:8]) && link_b_lanes[7:0] == $past(samples[71:64])
          && link_a_lanes[23:16] == 8'h00;
  endproperty
  a_map4: assert property (p_map4) else $error("four-lane mapping wrong");
  property p_map17;
    (!pd && link == sltp_pkg::LS_DATA && test_act == sltp_pkg::T_NORMAL && fmt == sltp_pkg::FMT_SINGLE16)
      |=> link_a_lanes[63:56] == $past(samples[119:112]) && link_b_lanes[63:56] == $past(samples[127:120]);
  endproperty
  a_map17: assert property (p_map17) else $error("single-channel mapping wrong");
  property p_ramp;
    (link == sltp_pkg::LS_DATA && sync_req_n && run && test_act == sltp_pkg::T_RAMP && mask[1])
      |=> ramp == 8'($past(ramp) + 8'h01) && link_a_lanes[15:8] == $past(ramp);
  endproperty
  a_ramp: assert property (p_ramp) else $error("ramp not counting");
  property p_repila;
    test_act == sltp_pkg::T_REPILA && ctrl[sltp_pkg::CTRL_LINK_EN_BIT] |-> link != sltp_pkg::LS_DATA;
  endproperty
  a_repila: assert property (p_repila) else $error("data phase in repeated alignment");
  property p_resync;
    (link == sltp_pkg::LS_ILAS && run && !sync_req_n) |=> link == sltp_pkg::LS_CGS ##1 lane_k[0];
  endproperty
  a_resync: assert property (p_resync) else $error("sync request not answered");
  property p_rpat;
    (!pd && mask[0] && link == sltp_pkg::LS_DATA && test_act == sltp_pkg::T_RPAT)
      |=> link_a_lanes[7:0] == sltp_pkg::sltp_rpat($past(rpat_idx));
  endproperty
  a_rpat: assert property (p_rpat) else $error("RPAT octet wrong");
  c_data: cover property (link == sltp_pkg::LS_CGS ##[1:300] link == sltp_pkg::LS_DATA);
  c_prbs: cover property (lane_raw[0] ##1 lane_raw[0]);
  c_stp:  cover property (link == sltp_pkg::LS_DATA && test_act == sltp_pkg::T_STP ##2 stp);
endmodule : sltp_lane_fmt

// ### sltp_pkg.sv
// Constants, codes and register map of the lane formatter and test-pattern generator
package sltp_pkg;
  // Register byte offsets
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_FMT  = 12'h004;
  localparam logic [11:0] ADDR_TEST = 12'h008;
  localparam logic [11:0] ADDR_STAT = 12'h00C;
  // Control register fields
  localparam int CTRL_LINK_EN_BIT = 0;
  localparam int CTRL_PWRDN_BIT   = 1;
  // Status register field positions
  localparam int STAT_LINK_LSB  = 0;
  localparam int STAT_PD_BIT    = 4;
  localparam int STAT_LANE_LSB  = 8;
  localparam int STAT_TEST_LSB  = 28;
  // Reset values
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [4:0] FMT_RST  = 5'h12;
  localparam logic [3:0] TEST_RST = 4'h0;
  // Link format codes
  localparam logic [4:0] FMT_DUAL4    = 5'h06;
  localparam logic [4:0] FMT_DUAL8    = 5'h07;
  localparam logic [4:0] FMT_SINGLE16 = 5'h11;
  localparam logic [4:0] FMT_DUAL16   = 5'h12;
  // Test pattern codes
  localparam logic [3:0] T_NORMAL = 4'h0;
  localparam logic [3:0] T_PRBS7  = 4'h1;
  localparam logic [3:0] T_PRBS15 = 4'h2;
  localparam logic [3:0] T_PRBS23 = 4'h3;
  localparam logic [3:0] T_RAMP   = 4'h4;
  localparam logic [3:0] T_STP    = 4'h5;
  localparam logic [3:0] T_D21_5  = 4'h6;
  localparam logic [3:0] T_K28_5  = 4'h7;
  localparam logic [3:0] T_REPILA = 4'h8;
  localparam logic [3:0] T_RPAT   = 4'h9;
  // Character codes
  localparam logic [7:0] CH_K28_5 = 8'hBC;
  localparam logic [7:0] CH_K28_0 = 8'h1C;
  localparam logic [7:0] CH_K28_3 = 8'h7C;
  localparam logic [7:0] CH_D21_5 = 8'hB5;
  // Alignment sequence shape, pattern lengths and PRBS seed
  localparam int ILAS_MF_COUNT = 4;
  localparam int MF_OCTETS     = 32;
  localparam logic [3:0] RPAT_LAST = 4'hB;
  localparam logic [22:0] PRBS_SEED = 23'h2A5500;
  // Link state, one-hot
  typedef enum logic [3:0] {
    LS_OFF  = 4'b0001,
    LS_CGS  = 4'b0010,
    LS_ILAS = 4'b0100,
    LS_DATA = 4'b1000
  } sltp_link_e;
  // Twelve-octet jitter pattern
  function automatic logic [7:0] sltp_rpat(input logic [3:0] idx);
    logic [7:0] v;
    case (idx)
      4'h0: v = 8'hBE;
      4'h1: v = 8'hD7;
      4'h2: v = 8'h23;
      4'h3: v = 8'h47;
      4'h4: v = 8'h6B;
      4'h5: v = 8'h8F;
      4'h6: v = 8'hB3;
      4'h7: v = 8'h14;
      4'h8: v = 8'h5E;
      4'h9: v = 8'hFB;
      4'hA: v = 8'h35;
      default: v = 8'h59;
    endcase
    return v;
  endfunction : sltp_rpat
endpackage : sltp_pkg

// ### sltp_rx_model.sv
// Receiver partner model: drives the sync request from lane 0 traffic
`timescale 1ns/1ps
module sltp_rx_model (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic [7:0] lane0,
  input  wire logic       k0,
  input  wire logic       drv_en0,
  input  wire logic       resync,
  output logic            sync_req_n
);
  logic [2:0] cnt;

  // relink after lane loss or on demand
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync_req_n <= 1'b0;
      cnt        <= 3'h0;
    end else if (!drv_en0 || resync) begin
      sync_req_n <= 1'b0;
      cnt        <= 3'h0;
    end else if (!sync_req_n) begin
      // Four clean commas end code group sync
      cnt        <= (k0 && lane0 == 8'hBC) ? cnt + 3'h1 : 3'h0;
      sync_req_n <= (cnt == 3'h3) && k0 && (lane0 == 8'hBC);
    end
  end
endmodule : sltp_rx_model

// ### tb_top.sv
// Self-checking bench for the lane formatter and test-pattern generator
`timescale 1ns/1ps
module tb_top;
  logic         clk, sys_rst, psel, penable, pwrite, powerdown_pin, resync;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, prdata, rd;
  logic         pready, pslverr, sync_req_n, er;
  logic [127:0] samples, smp;
  logic [63:0]  link_a_lanes, link_b_lanes, pa, pb;
  logic [15:0]  lane_k, lane_raw, lane_drive_en;
  logic [7:0]   mk;
  logic [4:0]   fl [4];
  logic [3:0]   tm [5];
  int           err_count, n_checks, i, m, n, e;
  logic [7:0]   rpt [12] = '{8'hBE, 8'hD7, 8'h23, 8'h47, 8'h6B, 8'h8F, 8'hB3, 8'h14, 8'h5E, 8'hFB, 8'h35, 8'h59};

  sltp_lane_fmt sltp_lane_fmt_i (.clk, .sys_rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .powerdown_pin, .sync_req_n, .samples, .link_a_lanes, .link_b_lanes, .lane_k, .lane_raw,
    .lane_drive_en);
  sltp_rx_model sltp_rx_model_i (.clk, .sys_rst, .lane0(link_a_lanes[7:0]), .k0(lane_k[0]),
    .drv_en0(lane_drive_en[0]), .resync, .sync_req_n);

  // Clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Watchdog
  initial begin
    repeat (40000) @(posedge clk);
    err_count++;
    report_and_stop();
  end

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] g);
    n_checks++;
    if (g !== ex) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, g);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop

  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    // Wait for the answer; only the watchdog ends a hung transfer
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1);
    chk("pready wait", 32'h2, k);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wait_state(input logic [3:0] s);
    int k;
    k = 0;
    do begin
      apb(1'b0, sltp_pkg::ADDR_STAT, 32'h0);
      k++;
    end while (rd[3:0] !== s && k < 100);
    chk("link state", {28'h0, s}, {28'h0, rd[3:0]});
  endtask : wait_state

  task automatic start(input logic [4:0] f, input logic [3:0] t);
    apb(1'b1, sltp_pkg::ADDR_CTRL, 32'h0);
    apb(1'b1, sltp_pkg::ADDR_TEST, {28'h0, t});
    apb(1'b1, sltp_pkg::ADDR_FMT, {27'h0, f});
    apb(1'b1, sltp_pkg::ADDR_CTRL, 32'h1);
  endtask : start

  function automatic logic [7:0] lane(input int k);
    return k < 8 ? link_a_lanes[8*k+:8] : link_b_lanes[8*(k-8)+:8];
  endfunction : lane

  function automatic int nl(input logic [4:0] f);
    return f == sltp_pkg::FMT_DUAL4 ? 2 : f == sltp_pkg::FMT_DUAL8 ? 4 : 8;
  endfunction : nl

  function automatic logic [7:0] exp_map(input logic [4:0] f, input logic [127:0] s, input int k);
    int o;
    o = (f == sltp_pkg::FMT_SINGLE16) ? 2 * (k % 8) + k / 8 : k;
    return s[8*o+:8];
  endfunction : exp_map

  function automatic logic [7:0] pat(input logic [3:0] t, input int st, input int c, input int j);
    case (t)
      sltp_pkg::T_RAMP:  return 8'(st + c);
      sltp_pkg::T_STP:   return ((st + c) % 2) ? ~8'(j) : 8'(j);
      sltp_pkg::T_RPAT:  return rpt[(st + c) % 12];
      sltp_pkg::T_D21_5: return 8'hB5;
      default:           return 8'hBC;
    endcase
  endfunction : pat

  // Runs one octet-pattern mode on four lanes of each link
  task automatic run_pat(input logic [3:0] t);
    int st, c, k;
    start(sltp_pkg::FMT_DUAL8, t);
    if (t inside {sltp_pkg::T_RAMP, sltp_pkg::T_STP, sltp_pkg::T_RPAT}) wait_state(4'h8);
    else repeat (6) @(posedge clk);
    @(posedge clk);
    #1;
    st = (t == sltp_pkg::T_STP) ? int'(lane(0) != 8'h00) : int'(lane(0));
    for (k = 0; k < 12; k++)
      if (t == sltp_pkg::T_RPAT && rpt[k] === lane(0)) st = k;
    for (c = 0; c < 300; c++) begin
      for (k = 0; k < 16; k++)
        if (k % 8 < 4) chk("pattern octet", {24'h0, pat(t, st, c, k % 8)}, {24'h0, lane(k)});
      chk("k flag", {31'h0, t == sltp_pkg::T_K28_5}, {31'h0, lane_k[0]});
      @(posedge clk);
      #1;
    end
    $display("pattern mode %0d done", t);
  endtask : run_pat

  initial begin
    {psel, penable, pwrite, powerdown_pin, resync, paddr, pwdata, samples} = '0;
    err_count = 0;
    n_checks  = 0;
    sys_rst   = 1'b1;
    void'($urandom(32'hAC97));
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    // Reset values and unmapped access
    apb(1'b0, sltp_pkg::ADDR_FMT, 32'h0);
    chk("fmt reset", 32'h12, rd);
    apb(1'b0, sltp_pkg::ADDR_STAT, 32'h0);
    // Link off, lanes of the reset format powered, normal pattern
    chk("stat reset", 32'h00FFFF01, rd);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, er});
    chk("unmapped data", 32'h0, rd);
    $display("register test done");
    // Sample mapping in every link format
    fl = '{sltp_pkg::FMT_DUAL4, sltp_pkg::FMT_DUAL8, sltp_pkg::FMT_SINGLE16, sltp_pkg::FMT_DUAL16};
    for (m = 0; m < 4; m++) begin
      start(fl[m], sltp_pkg::T_NORMAL);
      wait_state(4'h8);
      mk = 8'((1 << nl(fl[m])) - 1);
      chk("drive enable", {16'h0, mk, mk}, {16'h0, lane_drive_en});
      repeat (20) begin
        @(posedge clk);
        smp = {$urandom(), $urandom(), $urandom(), $urandom()};
        samples <= smp;
        @(posedge clk);
        #1;
        for (i = 0; i < 16; i++)
          if (i % 8 < nl(fl[m])) chk("lane octet", {24'h0, exp_map(fl[m], smp, i)}, {24'h0, lane(i)});
      end
      $display("format %0d done", fl[m]);
    end
    // PRBS recurrence and lane phase
    for (m = 1; m <= 3; m++) begin
      start(sltp_pkg::FMT_DUAL8, 4'(m));
      repeat (5) @(posedge clk);
      #1;
      chk("raw flag", 32'h1, {31'h0, lane_raw[0]});
      for (i = 0; i < 8; i++) begin
        @(posedge clk);
        #1;
        pa = {pa[55:0], link_a_lanes[7:0]};
        pb = {pb[55:0], link_a_lanes[15:8]};
      end
      e = 0;
      for (n = 23; n < 64; n++)
        if (pa[63-n] !== (pa[63-n+(m==1?6:m==2?14:18)] ^ pa[63-n+(m==1?7:m==2?15:23)])) e++;
      chk("prbs recurrence", 32'h0, e);
      chk("lane phase", 32'h1, {31'h0, pa !== pb});
      $display("prbs mode %0d done", m);
    end
    tm = '{sltp_pkg::T_RAMP, sltp_pkg::T_STP, sltp_pkg::T_D21_5, sltp_pkg::T_K28_5, sltp_pkg::T_RPAT};
    for (m = 0; m < 5; m++) run_pat(tm[m]);
    // Repeated alignment with a sync request
    start(sltp_pkg::FMT_DUAL8, sltp_pkg::T_REPILA);
    repeat (400) @(posedge clk);
    apb(1'b0, sltp_pkg::ADDR_STAT, 32'h0);
    chk("no data phase", 32'h4, {28'h0, rd[3:0]});
    resync <= 1'b1;
    @(posedge clk);
    resync <= 1'b0;
    n = 0;
    repeat (8) begin
      @(posedge clk);
      #1;
      if (lane_k[0] === 1'b1 && lane(0) === 8'hBC) n = 1;
    end
    chk("resync comma", 32'h1, n);
    wait_state(4'h4);
    $display("repeated alignment done");
    // Power-down by pin, then by register
    start(sltp_pkg::FMT_DUAL16, sltp_pkg::T_NORMAL);
    wait_state(4'h8);
    powerdown_pin <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk("pin power-down", 32'h0, {16'h0, lane_drive_en});
    @(posedge clk);
    powerdown_pin <= 1'b0;
    wait_state(4'h8);
    apb(1'b1, sltp_pkg::ADDR_CTRL, 32'h3);
    repeat (3) @(posedge clk);
    #1;
    chk("reg power-down", 32'h0, {16'h0, lane_drive_en});
    apb(1'b0, sltp_pkg::ADDR_STAT, 32'h0);
    chk("power-down flag", 32'h1, {31'h0, rd[4]});
    $display("power-down done");
    report_and_stop();
  end
endmodule : tb_top
